// ---- hdl/fpwg_pkg.sv ----
package fpwg_pkg;
    localparam logic [7:0]  KEY_FIRST      = 8'ha5;
    localparam logic [7:0]  KEY_SECOND     = 8'hf1;
    localparam int          FLASH_AW       = 13;
    localparam logic [12:0] PAGE_MASK      = 13'h1e00;
    localparam logic [12:0] RESV_START     = 13'h1e00;
    localparam logic [12:0] LOCK_BYTE_ADDR = 13'h1dff;
    localparam logic [7:0]  LOCK_OPEN      = 8'hff;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
    localparam int          FLASH_BYTES    = 8192;
    localparam int          PAGE_BYTES     = 512;
    localparam int          PAGE_CNT_W     = 9;
    localparam logic [8:0]  PAGE_LAST      = 9'h1ff;
    localparam bit          CTRL_RESET     = 1'b0;
endpackage : fpwg_pkg

// ---- hdl/fpwg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fpwg_if (
    input wire logic ref_clk,
    input wire logic resetn
);
    import fpwg_pkg::*;
    logic                program_store_write_enable;
    logic                program_store_erase_enable;
    logic                key_wr;
    logic [7:0]          flash_unlock_key;
    logic                xdata_wr;
    logic [FLASH_AW-1:0] xdata_addr;
    logic [7:0]          xdata_wdata;
    logic                code_rd;
    logic [FLASH_AW-1:0] code_addr;
    logic [7:0]          code_rdata;
    logic                busy;
    logic                refused;
    logic                xdata_to_ram;

    modport dev (
        input  program_store_write_enable, program_store_erase_enable, key_wr,
        input  flash_unlock_key, xdata_wr, xdata_addr, xdata_wdata, code_rd, code_addr,
        output code_rdata, busy, refused, xdata_to_ram
    );
    modport cpu (
        output program_store_write_enable, program_store_erase_enable, key_wr,
        output flash_unlock_key, xdata_wr, xdata_addr, xdata_wdata, code_rd, code_addr,
        input  code_rdata, busy, refused, xdata_to_ram
    );
endinterface : fpwg_if
`default_nettype wire

// ---- hdl/fpwg_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpwg_device
    import fpwg_pkg::*;
(
    input  wire logic    ref_clk,
    input  wire logic    resetn,
    fpwg_if.dev          bus,
    input  wire logic                debug_rd,
    input  wire logic                debug_wr,
    input  wire logic [FLASH_AW-1:0] debug_addr,
    input  wire logic [7:0]          debug_wdata,
    output logic [7:0]               debug_rdata,
    output logic                     debug_denied
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_KEY1  = 3'b010,
        ST_ARMED = 3'b100
    } fpwg_unlock_e;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b01,
        OP_ERASE = 2'b10
    } fpwg_op_e;

    typedef struct packed {
        fpwg_unlock_e        ul;
        fpwg_op_e            op;
        logic [PAGE_CNT_W-1:0] cnt;
        logic [FLASH_AW-1:0] page;
        logic [7:0]          crd;
        logic                refused;
        logic [7:0]          drd;
        logic                denied;
    } fpwg_state_s;

    // Flash array stays out of the struct; it is storage, not control
    logic [7:0] mem [FLASH_BYTES];

    fpwg_state_s s_q;
    fpwg_state_s s_d;
    logic        prog_we;
    logic        erase_we;
    logic        dbg_we;
    logic        locked;

    // Any lock value other than erased shuts the debug link out
    assign locked = (mem[LOCK_BYTE_ADDR] != LOCK_OPEN);

    always_comb begin
        s_d      = s_q;
        prog_we  = 1'b0;
        erase_we = 1'b0;
        dbg_we   = 1'b0;
        s_d.refused = 1'b0;
        s_d.denied  = 1'b0;
        if (bus.key_wr) begin
            unique case (s_q.ul)
                ST_IDLE:  s_d.ul = (bus.flash_unlock_key == KEY_FIRST) ? ST_KEY1 : ST_IDLE;
                ST_KEY1:  s_d.ul = (bus.flash_unlock_key == KEY_SECOND) ? ST_ARMED : ST_IDLE;
                ST_ARMED: s_d.ul = ST_IDLE;
                default:  s_d.ul = ST_IDLE;
            endcase
        end
        if (s_q.op == OP_ERASE) begin
            s_d.cnt = s_q.cnt + 9'h001;
            erase_we = 1'b1;
            if (s_q.cnt == PAGE_LAST) begin
                s_d.op = OP_NONE;
            end
        end else if (bus.xdata_wr && bus.program_store_write_enable) begin
            // A write that is refused still burns the unlock
            s_d.ul = ST_IDLE;
            if (s_q.ul != ST_ARMED) begin
                s_d.refused = 1'b1;
            end else if (bus.program_store_erase_enable) begin
                s_d.op   = OP_ERASE;
                s_d.cnt  = '0;
                s_d.page = bus.xdata_addr & PAGE_MASK;
            end else begin
                prog_we = 1'b1;
            end
        end
        if (bus.code_rd) begin
            s_d.crd = mem[bus.code_addr];
        end
        if (debug_rd || debug_wr) begin
            if (locked) begin
                s_d.denied = 1'b1;
            end else if (debug_wr) begin
                dbg_we = 1'b1;
            end else begin
                s_d.drd = mem[debug_addr];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{ul: ST_IDLE, op: OP_NONE, cnt: '0, page: '0, crd: '0,
                     refused: CTRL_RESET, drd: '0, denied: CTRL_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // Programming only clears bits, as a real flash cell would
    always_ff @(posedge ref_clk) begin
        if (erase_we) begin
            mem[s_q.page | {4'h0, s_q.cnt}] <= ERASED_BYTE;
        end else if (prog_we) begin
            mem[bus.xdata_addr] <= mem[bus.xdata_addr] & bus.xdata_wdata;
        end else if (dbg_we) begin
            mem[debug_addr] <= mem[debug_addr] & debug_wdata;
        end
    end

    assign bus.code_rdata   = s_q.crd;
    assign bus.busy         = (s_q.op == OP_ERASE);
    assign bus.refused      = s_q.refused;
    assign bus.xdata_to_ram = !bus.program_store_write_enable;
    assign debug_rdata      = s_q.drd;
    assign debug_denied     = s_q.denied;
endmodule : fpwg_device
`default_nettype wire

// ---- hdl/fpwg_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpwg_cpu
    import fpwg_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    fpwg_if.cpu                      bus,
    input  wire logic                req_write,
    input  wire logic                req_erase,
    input  wire logic                req_read,
    input  wire logic [FLASH_AW-1:0] req_addr,
    input  wire logic [7:0]          req_data,
    output logic                     req_ready,
    output logic                     irq_hold,
    output logic                     done,
    output logic                     err,
    output logic [7:0]               rd_data
);
    typedef enum logic [7:0] {
        C_IDLE  = 8'h01,
        C_EN    = 8'h02,
        C_K1    = 8'h04,
        C_K2    = 8'h08,
        C_ACC   = 8'h10,
        C_WAIT  = 8'h20,
        C_OFF   = 8'h40,
        C_RD    = 8'h80
    } fpwg_cpu_e;

    typedef struct packed {
        fpwg_cpu_e           st;
        logic                erase;
        logic [FLASH_AW-1:0] addr;
        logic [7:0]          data;
        logic                we;
        logic                ee;
        logic                done;
        logic                err;
        logic [7:0]          rd;
    } fpwg_cpu_s;

    fpwg_cpu_s c_q;
    fpwg_cpu_s c_d;

    always_comb begin
        c_d      = c_q;
        c_d.done = 1'b0;
        c_d.err  = 1'b0;
        unique case (c_q.st)
            C_IDLE: begin
                if (req_read) begin
                    c_d.addr = req_addr;
                    c_d.st   = C_RD;
                end else if (req_write || req_erase) begin
                    c_d.addr  = req_addr;
                    c_d.data  = req_data;
                    c_d.erase = req_erase;
                    // Reserved top region is never targeted
                    if (req_addr >= RESV_START) begin
                        c_d.err  = 1'b1;
                        c_d.done = 1'b1;
                    end else begin
                        c_d.st = C_EN;
                    end
                end
            end
            C_EN: begin
                c_d.we = 1'b1;
                c_d.ee = c_q.erase;
                c_d.st = C_K1;
            end
            C_K1: c_d.st = C_K2;
            C_K2: c_d.st = C_ACC;
            C_ACC: c_d.st = C_WAIT;
            C_WAIT: begin
                if (!bus.busy) begin
                    c_d.err = bus.refused;
                    c_d.st  = C_OFF;
                end
            end
            C_OFF: begin
                c_d.we   = 1'b0;
                c_d.ee   = 1'b0;
                c_d.done = 1'b1;
                c_d.st   = C_IDLE;
            end
            C_RD: begin
                c_d.rd   = bus.code_rdata;
                c_d.done = 1'b1;
                c_d.st   = C_IDLE;
            end
            default: c_d.st = C_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            c_q <= '{st: C_IDLE, erase: 1'b0, addr: '0, data: '0, we: 1'b0,
                     ee: 1'b0, done: 1'b0, err: 1'b0, rd: '0};
        end else begin
            c_q <= c_d;
        end
    end

    // Erase of the page must be requested before byte writes there
    assign bus.program_store_write_enable = c_q.we;
    assign bus.program_store_erase_enable = c_q.ee;
    assign bus.key_wr           = (c_q.st == C_K1) || (c_q.st == C_K2);
    assign bus.flash_unlock_key = (c_q.st == C_K1) ? KEY_FIRST : KEY_SECOND;
    assign bus.xdata_wr         = (c_q.st == C_ACC);
    assign bus.xdata_addr       = c_q.addr;
    assign bus.xdata_wdata      = c_q.data;
    assign bus.code_rd          = (c_q.st == C_IDLE) && req_read;
    assign bus.code_addr        = req_addr;
    assign req_ready            = (c_q.st == C_IDLE);
    assign irq_hold             = (c_q.st != C_IDLE) && (c_q.st != C_RD);
    assign done                 = c_q.done;
    assign err                  = c_q.err;
    assign rd_data              = c_q.rd;
endmodule : fpwg_cpu
`default_nettype wire

// ---- tb/fpwg_chk_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpwg_chk_props
    import fpwg_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       program_store_write_enable,
    input wire logic       program_store_erase_enable,
    input wire logic       key_wr,
    input wire logic [7:0] flash_unlock_key,
    input wire logic       xdata_wr,
    input wire logic       busy,
    input wire logic       refused,
    input wire logic       xdata_to_ram
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Counts busy cycles so the erase length is held to the exact page size
    logic [9:0] busy_run_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_run_q <= 10'h000;
        end else begin
            busy_run_q <= busy ? busy_run_q + 10'h001 : 10'h000;
        end
    end
    chk_route_to_ram: assert property (xdata_to_ram == !program_store_write_enable)
        else $error("route wrong");
    chk_erase_enables: assert property ($rose(busy) |->
        program_store_write_enable && program_store_erase_enable)
        else $error("erase without enables");
    chk_erase_length: assert property ($fell(busy) |-> busy_run_q == 10'(PAGE_BYTES))
        else $error("erase length");
    chk_key_order: assert property (key_wr && flash_unlock_key == KEY_SECOND |->
        $past(key_wr) && $past(flash_unlock_key) == KEY_FIRST)
        else $error("key order");
    chk_write_unlocked: assert property (xdata_wr |->
        $past(key_wr) && $past(flash_unlock_key) == KEY_SECOND)
        else $error("write without unlock");
    chk_write_enabled: assert property (xdata_wr |-> program_store_write_enable)
        else $error("write enable low");
    chk_enable_cleared: assert property (xdata_wr && !program_store_erase_enable |->
        ##[1:4] !program_store_write_enable)
        else $error("enable left set");
    chk_no_refuse: assert property (!refused)
        else $error("unexpected refusal");
endmodule : fpwg_chk_props
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb;
    import fpwg_pkg::*;
    logic                ref_clk, resetn, rw, re, rr, rdy, irq, done, err;
    logic                dbg_rd, dbg_wr, den, e, f;
    logic [FLASH_AW-1:0] ra, dbg_a, a;
    logic [7:0]          rdat, rd, dbg_q, q, d, d2;
    int                  fails = 0;
    int                  n_tests = 0;
    fpwg_if i_if (.ref_clk, .resetn);
    fpwg_if i_if_b (.ref_clk, .resetn);
    fpwg_cpu i_fpwg_cpu (.ref_clk, .resetn, .bus(i_if), .req_write(rw), .req_erase(re),
        .req_read(rr), .req_addr(ra), .req_data(rdat), .req_ready(rdy), .irq_hold(irq),
        .done, .err, .rd_data(rd));
    fpwg_device i_fpwg_device (.ref_clk, .resetn, .bus(i_if), .debug_rd(dbg_rd),
        .debug_wr(dbg_wr), .debug_addr(dbg_a), .debug_wdata(rdat), .debug_rdata(dbg_q),
        .debug_denied(den));
    // Rule-breaking driver side: refusals are judged here, not by the checker
    fpwg_device i_fpwg_device_b (.ref_clk, .resetn, .bus(i_if_b), .debug_rd(dbg_rd),
        .debug_wr(dbg_wr), .debug_addr(dbg_a), .debug_wdata(rdat), .debug_rdata(),
        .debug_denied());
    fpwg_chk_props i_fpwg_chk_props (.ref_clk, .resetn,
        .program_store_write_enable(i_if.program_store_write_enable),
        .program_store_erase_enable(i_if.program_store_erase_enable),
        .key_wr(i_if.key_wr), .flash_unlock_key(i_if.flash_unlock_key),
        .xdata_wr(i_if.xdata_wr), .busy(i_if.busy), .refused(i_if.refused),
        .xdata_to_ram(i_if.xdata_to_ram));
    function automatic logic [7:0] prog(input logic [7:0] o, input logic [7:0] n);
        return o & n;
    endfunction : prog
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic req(input logic w, input logic er, input logic r,
                       input logic [FLASH_AW-1:0] ad, input logic [7:0] dv);
        int k;
        k = 0;
        @(posedge ref_clk);
        {rw, re, rr, ra, rdat} <= {w, er, r, ad, dv};
        @(negedge ref_clk);
        while (rdy !== 1'b1 && k++ < 50) @(negedge ref_clk);
        if (rdy !== 1'b1) fails++;
        @(posedge ref_clk);
        {rw, re, rr} <= 3'b000;
        @(negedge ref_clk);
        if (!r && ad < RESV_START) `CHK(irq, 1'b1)
        k = 0;
        e = 1'b0;
        // The error pulse may come the cycle before done, so gather it while waiting
        while (done !== 1'b1 && k++ < 700) begin
            e = e | err;
            @(negedge ref_clk);
        end
        if (done !== 1'b1) fails++;
        q = rd;
        e = e | err;
    endtask : req
    task automatic bw(input logic k, input logic [7:0] v, input logic x);
        @(posedge ref_clk);
        {i_if_b.key_wr, i_if_b.xdata_wr, i_if_b.flash_unlock_key} <= {k, !k, v};
        i_if_b.xdata_wdata <= v;
        @(posedge ref_clk);
        {i_if_b.key_wr, i_if_b.xdata_wr} <= 2'b00;
        f = 1'b0;
        repeat (3) @(negedge ref_clk) f = f | i_if_b.refused;
        if (!k) `CHK(f, x)
    endtask : bw
    task automatic dbg(input logic wr, input logic x);
        @(posedge ref_clk);
        {dbg_rd, dbg_wr, dbg_a} <= {!wr, wr, LOCK_BYTE_ADDR};
        @(posedge ref_clk);
        {dbg_rd, dbg_wr} <= 2'b00;
        f = 1'b0;
        repeat (3) @(negedge ref_clk) f = f | den;
        `CHK(f, x)
    endtask : dbg
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        close_out();
    end
    initial begin
        {resetn, rw, re, rr, dbg_rd, dbg_wr, ra, rdat, dbg_a} = '0;
        {i_if_b.key_wr, i_if_b.xdata_wr, i_if_b.code_rd, i_if_b.code_addr} = '0;
        {i_if_b.program_store_write_enable, i_if_b.program_store_erase_enable} = 2'b00;
        {i_if_b.flash_unlock_key, i_if_b.xdata_wdata, i_if_b.xdata_addr} = {16'h0, 13'h0100};
        void'($urandom(60249));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            a = 13'($urandom % 13'h1c00);
            d = 8'($urandom);
            d2 = 8'($urandom);
            req(0, 1, 0, a, 8'h00);
            `CHK(e, 1'b0)
            req(0, 0, 1, a ^ 13'h0001, 8'h00);
            `CHK(q, ERASED_BYTE)
            req(1, 0, 0, a, d);
            req(1, 0, 0, a, d2);
            req(0, 0, 1, a, 8'h00);
            `CHK(q, prog(d, d2))
        end
        req(1, 0, 0, RESV_START + 13'($urandom % PAGE_BYTES), 8'h00);
        `CHK(e, 1'b1)
        req(0, 1, 0, 13'h1fff, 8'h00);
        `CHK(e, 1'b1)
        req(0, 1, 0, LOCK_BYTE_ADDR, 8'h00);
        dbg(0, 1'b0);
        `CHK(dbg_q, ERASED_BYTE)
        req(1, 0, 0, LOCK_BYTE_ADDR, 8'h3c);
        dbg(0, 1'b1);
        `CHK(dbg_q, ERASED_BYTE)
        dbg(1, 1'b1);
        @(posedge ref_clk);
        i_if_b.program_store_write_enable <= 1'b1;
        bw(0, d, 1'b1);
        bw(1, KEY_SECOND, 1'b0);
        bw(0, d, 1'b1);
        bw(1, KEY_FIRST, 1'b0);
        bw(1, 8'h5a, 1'b0);
        bw(1, KEY_SECOND, 1'b0);
        bw(0, d, 1'b1);
        bw(1, KEY_FIRST, 1'b0);
        bw(1, KEY_SECOND, 1'b0);
        bw(0, d, 1'b0);
        bw(0, d, 1'b1);
        // A key written while armed must throw the unlock away
        bw(1, KEY_FIRST, 1'b0);
        bw(1, KEY_SECOND, 1'b0);
        bw(1, KEY_FIRST, 1'b0);
        bw(0, d, 1'b1);
        close_out();
    end
endmodule : tb
`default_nettype wire
